/* File: rtl/cic_defines.svh */
`ifndef CIC_DEFINES_SVH
`define CIC_DEFINES_SVH

// Register word offsets (byte addresses)
`define CIC_SENS_OFS 8'h00
`define CIC_PINSEL_OFS 8'h04
`define CIC_FLAGS_OFS 8'h08
`define CIC_PEND_OFS 8'h0c
`define CIC_PEN_OFS 8'h10
`define CIC_POWER_OFS 8'h14
`define CIC_STATUS_OFS 8'h18

// Reset values
`define CIC_SENS_RST 8'h00
`define CIC_PINSEL_RST 8'h0c
`define CIC_PEN_RST 16'h0000

// Flags word bit holding the global mask
`define CIC_FLAGS_MASK_BIT 3

// Vector table
`define CIC_VEC_RESET 16'hfffe
`define CIC_VEC_TRAP 16'hfffc
`define CIC_VEC_SRC0 16'hfffa

// Source numbers
`define CIC_SRC_AWU 0
`define CIC_SRC_EXT0 1
`define CIC_SRC_ATOVF 9
`define CIC_SRC_TB1 11
`define CIC_SRC_SPI 12

// Sources that may end full halt: external lines and serial peripheral
`define CIC_HALT_WAKE 14'h101e
// Sources that may end active halt besides source 0 (AWU, added in the core): timer overflow and timebase one
`define CIC_AHALT_WAKE 14'h0a00

`endif

/* File: rtl/cic_pkg.sv */
package cic_pkg;
	typedef enum logic [2:0] {
		CIC_RUN = 3'b000,
		CIC_PUSH = 3'b001,
		CIC_VECTOR = 3'b010,
		CIC_SERVICE = 3'b011,
		CIC_POP = 3'b100
	} cic_state_t;

	typedef enum logic [1:0] {
		CIC_PM_RUN = 2'b00,
		CIC_PM_WAIT = 2'b01,
		CIC_PM_HALT = 2'b10,
		CIC_PM_AHALT = 2'b11
	} cic_power_t;

	typedef enum logic [1:0] {
		CIC_TRIG_FALL_LOW = 2'b00,
		CIC_TRIG_RISE = 2'b01,
		CIC_TRIG_FALL = 2'b10,
		CIC_TRIG_BOTH = 2'b11
	} cic_trig_t;
endpackage

/* File: rtl/cic_core_interrupt_controller.sv */
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "cic_defines.svh"
// Summary of operation
// - Two request classes: maskable hardware sources and one non-maskable software trap.
// - Maskable requests are served only with mask clear; held requests wait meanwhile.
// - Reset leaves the global mask set so nothing maskable is served.
// - Entry finishes instruction, pushes PC X A flags, sets mask, loads vector.
// - Return from service restores saved registers, clearing mask and resuming.
// - Entry sets the mask so a routine is not preempted by default.
// - Fixed priority: reset, trap, then sources 0 to 13 ascending; here source 13 never requests, so only 0 to 12 are served.
// - Reset FFFE, trap FFFC, each source next lower pair down to FFE0.
// - Any request ends wait; only external, serial and reset end full halt.
// - Only reset, source 0 (AWU), timer overflow and timebase one end active halt.
// - Trap taken whenever its instruction runs, ignoring mask, same entry.
// - External vector taken only after line event with mask clear; wakes halt.
// - Edge events latch and clear automatically on entering their routine.
// - Peripheral flag requests only with mask clear and enable set; else pending.
// - Peripheral request cleared by writing zero or status-then-associated access.
// - Clearing sequence resets the latch, discarding a masked pending request.
// - Sensitivity register: four two-bit fields, line 3 top down to line 0.
// - Codes: 00 falling and low, 01 rising, 10 falling, 11 both edges.
// - Sensitivity register accepts writes only while the global mask is set.
// - Sensitivity applies to whichever pin is routed to the line.
// - Pin choice field per line selects the driving port pin; line 3 B0-B2.
module cic_core_interrupt_controller #(
	parameter int NSRC = 14
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Port pins feeding the external lines
	input wire logic [7:0] port_a_i,
	input wire logic [6:0] port_b_i,
	// Peripheral status flags (level, raised by the peripheral)
	input wire logic [NSRC-1:0] periph_flag_i,
	// Peripheral clearing sequence completed (one-cycle pulse)
	input wire logic [NSRC-1:0] periph_clear_i,
	// CPU core side
	input wire logic insn_boundary_i,
	input wire logic trap_exec_i,
	input wire logic return_from_service_i,
	input wire logic push_done_i,
	input wire logic pop_done_i,
	input wire logic [7:0] popped_flags_word_i,
	output logic push_req_o,
	output logic pop_req_o,
	output logic vector_valid_o,
	output logic [15:0] vector_addr_o,
	output logic wake_o,
	output logic [7:0] flags_word_o
);
	// ============================================================
	// Registers
	// ============================================================
	logic [7:0] sens_q;
	logic [7:0] pinsel_q;
	logic [7:0] flags_word_q;
	logic [NSRC-1:0] pen_q;
	logic [NSRC-1:0] pend_q;
	logic [3:0] ext_lat_q;
	logic [3:0] ext_prev_q;
	cic_pkg::cic_power_t power_q;
	cic_pkg::cic_state_t state_q;
	logic trap_q;
	logic [4:0] sel_q;
	logic ack_q;
	logic [31:0] rdat_q;

	logic mask;
	logic wr;
	logic rd;
	logic [3:0] ext_pin;
	logic [3:0] ext_set;
	logic [3:0] ext_lvl;
	logic [NSRC-1:0] req;
	logic [NSRC-1:0] wake_set;
	logic [4:0] win;
	logic enter;
	logic wr_sens;
	logic wr_pinsel;
	logic wr_flags;
	logic wr_pend;
	logic wr_pen;
	logic wr_power;

	assign mask = flags_word_q[`CIC_FLAGS_MASK_BIT];
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];
	assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;

	// ============================================================
	// Write decode
	// ============================================================
	// A sensitivity write with the mask clear is acked but dropped
	always_comb begin
		wr_sens = 1'b0;
		wr_pinsel = 1'b0;
		wr_flags = 1'b0;
		wr_pend = 1'b0;
		wr_pen = 1'b0;
		wr_power = 1'b0;
		if (wr && wb_adr_i == `CIC_SENS_OFS) begin
			wr_sens = mask;
		end else if (wr && wb_adr_i == `CIC_PINSEL_OFS) begin
			wr_pinsel = 1'b1;
		end else if (wr && wb_adr_i == `CIC_FLAGS_OFS) begin
			wr_flags = 1'b1;
		end else if (wr && wb_adr_i == `CIC_PEND_OFS) begin
			wr_pend = 1'b1;
		end else if (wr && wb_adr_i == `CIC_PEN_OFS) begin
			wr_pen = wb_sel_i[1];
		end else if (wr && wb_adr_i == `CIC_POWER_OFS) begin
			wr_power = 1'b1;
		end
	end

	// ============================================================
	// Pin routing and sensitivity
	// ============================================================
	function automatic logic pick4(input logic [3:0] v, input logic [1:0] s);
		return v[s];
	endfunction

	// Code 00 reports only the falling edge here; its low level comes from ext_lvl
	function automatic logic edge_hit(input logic [1:0] code, input logic now, input logic prev);
		case (code)
			2'b00: return prev && !now;
			2'b01: return !prev && now;
			2'b10: return prev && !now;
			default: return prev != now;
		endcase
	endfunction

	always_comb begin
		ext_pin[3] = pinsel_q[7:6] == 2'b11 ? port_b_i[0] : pick4({port_b_i[0], port_b_i[2:0]}, pinsel_q[7:6]);
		ext_pin[2] = pick4(port_b_i[6:3], pinsel_q[5:4]);
		ext_pin[1] = pick4(port_a_i[7:4], pinsel_q[3:2]);
		ext_pin[0] = pick4(port_a_i[3:0], pinsel_q[1:0]);
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			ext_set[i] = edge_hit(sens_q[2*i+:2], ext_pin[i], ext_prev_q[i]);
			ext_lvl[i] = (sens_q[2*i+:2] == 2'b00) && !ext_pin[i];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_prev_q <= 4'hf;
		end else begin
			ext_prev_q <= ext_pin;
		end
	end

	// Edge latches clear when their routine is entered; a new edge wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_lat_q <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (ext_set[i]) begin
					ext_lat_q[i] <= 1'b1;
				end else if (enter && !trap_exec_i && win == 5'(`CIC_SRC_EXT0 + i)) begin
					ext_lat_q[i] <= 1'b0;
				end
			end
		end
	end

	// ============================================================
	// Peripheral pending latches
	// ============================================================
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_q <= '0;
		end else begin
			for (int i = 0; i < NSRC; i++) begin
				if (periph_flag_i[i]) begin
					pend_q[i] <= 1'b1;
				end else if (periph_clear_i[i]) begin
					pend_q[i] <= 1'b0;
				end else if (wr_pend && !wb_dat_i[i]) begin
					pend_q[i] <= 1'b0;
				end
			end
		end
	end

	// ============================================================
	// Arbitration
	// ============================================================
	always_comb begin
		req = pend_q & pen_q;
		req[NSRC-1] = 1'b0;
		for (int i = 0; i < 4; i++) begin
			req[`CIC_SRC_EXT0 + i] = ext_lat_q[i] || ext_lvl[i];
		end
	end

	// Scanning downward leaves the lowest pending number, the highest priority
	function automatic logic [4:0] first_set(input logic [NSRC-1:0] v);
		logic [4:0] r;
		r = 5'h1f;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction

	assign win = first_set(req);
	assign enter = state_q == cic_pkg::CIC_RUN && insn_boundary_i && (trap_exec_i || (!mask && win != 5'h1f));

	// ============================================================
	// Entry and return sequence
	// ============================================================
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= cic_pkg::CIC_RUN;
			trap_q <= 1'b0;
			sel_q <= 5'h00;
		end else begin
			case (state_q)
				cic_pkg::CIC_RUN: begin
					if (enter) begin
						trap_q <= trap_exec_i;
						sel_q <= win;
						state_q <= cic_pkg::CIC_PUSH;
					end else if (return_from_service_i) begin
						state_q <= cic_pkg::CIC_POP;
					end
				end
				cic_pkg::CIC_PUSH: begin
					if (push_done_i) begin
						state_q <= cic_pkg::CIC_VECTOR;
					end
				end
				cic_pkg::CIC_VECTOR: begin
					state_q <= cic_pkg::CIC_RUN;
				end
				cic_pkg::CIC_POP: begin
					if (pop_done_i) begin
						state_q <= cic_pkg::CIC_RUN;
					end
				end
				default: begin
					state_q <= cic_pkg::CIC_RUN;
				end
			endcase
		end
	end

	// Flags word: mask set at reset and at entry, cleared at return
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_word_q <= 8'h08;
		end else if (state_q == cic_pkg::CIC_PUSH && push_done_i) begin
			flags_word_q[`CIC_FLAGS_MASK_BIT] <= 1'b1;
		end else if (state_q == cic_pkg::CIC_POP && pop_done_i) begin
			flags_word_q <= popped_flags_word_i & 8'hf7;
		end else if (wr_flags) begin
			flags_word_q <= wb_dat_i[7:0];
		end else if (state_q == cic_pkg::CIC_RUN && power_q != cic_pkg::CIC_PM_RUN) begin
			flags_word_q[`CIC_FLAGS_MASK_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vector_addr_o <= `CIC_VEC_RESET;
			vector_valid_o <= 1'b0;
		end else begin
			vector_valid_o <= state_q == cic_pkg::CIC_PUSH && push_done_i;
			if (state_q == cic_pkg::CIC_PUSH && push_done_i) begin
				vector_addr_o <= trap_q ? `CIC_VEC_TRAP : 16'(`CIC_VEC_SRC0 - {10'h000, sel_q, 1'b0});
			end
		end
	end

	assign push_req_o = state_q == cic_pkg::CIC_PUSH;
	assign pop_req_o = state_q == cic_pkg::CIC_POP;
	assign flags_word_o = flags_word_q;

	// ============================================================
	// Low-power wake
	// ============================================================
	always_comb begin
		wake_set = '0;
		case (power_q)
			cic_pkg::CIC_PM_WAIT: wake_set = req;
			cic_pkg::CIC_PM_HALT: wake_set = req & `CIC_HALT_WAKE;
			cic_pkg::CIC_PM_AHALT: wake_set = req & (`CIC_AHALT_WAKE | 14'h0001);
			default: wake_set = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			power_q <= cic_pkg::CIC_PM_RUN;
			wake_o <= 1'b0;
		end else begin
			wake_o <= |wake_set;
			// A wake beats a power write in the same cycle so no request is slept through
			if (|wake_set) begin
				power_q <= cic_pkg::CIC_PM_RUN;
			end else if (wr_power) begin
				power_q <= cic_pkg::cic_power_t'(wb_dat_i[1:0]);
			end
		end
	end

	// ============================================================
	// Wishbone register file
	// ============================================================
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sens_q <= `CIC_SENS_RST;
			pinsel_q <= `CIC_PINSEL_RST;
			pen_q <= NSRC'(`CIC_PEN_RST);
		end else begin
			if (wr_sens) begin
				sens_q <= wb_dat_i[7:0];
			end
			if (wr_pinsel) begin
				pinsel_q <= wb_dat_i[7:0];
			end
			if (wr_pen) begin
				pen_q <= wb_dat_i[NSRC-1:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
			if (rd) begin
				if (wb_adr_i == `CIC_SENS_OFS) begin
					rdat_q <= {24'h000000, sens_q};
				end else if (wb_adr_i == `CIC_PINSEL_OFS) begin
					rdat_q <= {24'h000000, pinsel_q};
				end else if (wb_adr_i == `CIC_FLAGS_OFS) begin
					rdat_q <= {24'h000000, flags_word_q};
				end else if (wb_adr_i == `CIC_PEND_OFS) begin
					rdat_q <= {18'h00000, pend_q};
				end else if (wb_adr_i == `CIC_PEN_OFS) begin
					rdat_q <= {18'h00000, pen_q};
				end else if (wb_adr_i == `CIC_POWER_OFS) begin
					rdat_q <= {30'h00000000, power_q};
				end else if (wb_adr_i == `CIC_STATUS_OFS) begin
					rdat_q <= {20'h00000, ext_lat_q, state_q, sel_q};
				end else begin
					rdat_q <= 32'h0000_0000;
				end
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
endmodule

/* File: tb/cic_props.sv */
`timescale 1ns/1ps
// ====================
// Entry and return sequencing checks
module cic_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic insn_boundary_i,
	input wire logic trap_exec_i,
	input wire logic push_done_i,
	input wire logic pop_done_i,
	input wire logic push_req_o,
	input wire logic pop_req_o,
	input wire logic vector_valid_o,
	input wire logic [15:0] vector_addr_o,
	input wire logic [7:0] flags_word_o
);
	logic svc_q, trap_q, run;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	assign run = !svc_q && !push_req_o && !pop_req_o && !vector_valid_o;
	// Routine in progress, and a trap on its way to the vector fetch
	always_ff @(posedge clk_i) begin
		if (rst_i || pop_done_i) svc_q <= 1'b0;
		else if (vector_valid_o) svc_q <= 1'b1;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || vector_valid_o) trap_q <= 1'b0;
		else if (run && insn_boundary_i && trap_exec_i) trap_q <= 1'b1;
	end
	a_reset_masked: assert property ($fell(rst_i) |-> flags_word_o[3] && vector_addr_o == 16'hfffe)
		else $error("reset state wrong");
	a_masked_hold: assert property (run && insn_boundary_i && !trap_exec_i && flags_word_o[3] |=> !push_req_o)
		else $error("entry while masked");
	a_trap_taken: assert property (run && insn_boundary_i && trap_exec_i |=> push_req_o)
		else $error("trap not taken");
	a_push_vector: assert property (push_req_o && push_done_i |=> vector_valid_o && !push_req_o && flags_word_o[3])
		else $error("bad entry after push");
	a_vec_range: assert property (vector_valid_o |-> !vector_addr_o[0] && vector_addr_o inside {[16'hffe2:16'hfffc]})
		else $error("vector out of table");
	a_trap_vector: assert property (vector_valid_o && trap_q |-> vector_addr_o == 16'hfffc)
		else $error("trap vector wrong");
	a_no_preempt: assert property (svc_q && insn_boundary_i && !trap_exec_i |=> !push_req_o)
		else $error("routine preempted");
	a_return_unmask: assert property (pop_req_o && pop_done_i |=> !flags_word_o[3] && !pop_req_o)
		else $error("mask kept after return");
	c_trap: cover property (vector_valid_o && trap_q);
	c_masked: cover property (run && insn_boundary_i && flags_word_o[3]);
	c_return: cover property (pop_done_i);
endmodule
bind cic_core_interrupt_controller cic_props i_props (.clk_i, .rst_i, .insn_boundary_i, .trap_exec_i, .push_done_i,
	.pop_done_i, .push_req_o, .pop_req_o, .vector_valid_o, .vector_addr_o, .flags_word_o);

/* File: tb/cic_cpu_model.sv */
`timescale 1ns/1ps
// ====================
// CPU stack traffic, answering after dly_i+1 cycles
module cic_cpu_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic push_req_i,
	input wire logic pop_req_i,
	input wire logic [1:0] dly_i,
	output logic push_done_o,
	output logic pop_done_o,
	output logic [7:0] popped_flags_word_o
);
	logic [1:0] cnt_q;
	always_ff @(posedge clk_i) begin
		push_done_o <= 1'b0;
		pop_done_o <= 1'b0;
		if (rst_i || !(push_req_i || pop_req_i) || push_done_o || pop_done_o) cnt_q <= 2'h0;
		else if (cnt_q == dly_i) begin
			push_done_o <= push_req_i;
			pop_done_o <= pop_req_i;
		end else cnt_q <= cnt_q + 2'h1;
	end
	// Stack bus reads 00 during a pop and ff outside a pop
	assign popped_flags_word_o = pop_req_i ? 8'h00 : 8'hff;
endmodule

/* File: tb/tb_core_interrupt_controller.sv */
`timescale 1ns/1ps
`include "cic_defines.svh"
module tb_core_interrupt_controller;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, bnd = 1'b0, trap = 1'b0, rfs = 1'b0, h;
	logic [1:0] dly = 2'h0;
	logic [7:0] adr = 8'h00, pa = 8'hff, fw, popf;
	logic [6:0] pb = 7'h7f;
	logic [13:0] pf = 14'h0, pc = 14'h0;
	logic [13:0] wk_pf [6] = '{14'h20, 14'h1020, 14'h1020, 14'h1220, 14'h0, 14'h20};
	logic [31:0] wd = 32'h0, rd, dat;
	logic [15:0] va;
	logic ack, push_req, pop_req, push_done, pop_done, vv, wake;
	int fail_count = 0;
	int num_checks = 0;
	always #2 clk_i = ~clk_i;
	cic_core_interrupt_controller i_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack), .port_a_i(pa),
		.port_b_i(pb), .periph_flag_i(pf), .periph_clear_i(pc), .insn_boundary_i(bnd), .trap_exec_i(trap),
		.return_from_service_i(rfs), .push_done_i(push_done), .pop_done_i(pop_done), .popped_flags_word_i(popf),
		.push_req_o(push_req), .pop_req_o(pop_req), .vector_valid_o(vv), .vector_addr_o(va), .wake_o(wake),
		.flags_word_o(fw));
	cic_cpu_model i_cpu (.clk_i, .rst_i, .push_req_i(push_req), .pop_req_i(pop_req), .dly_i(dly),
		.push_done_o(push_done), .pop_done_o(pop_done), .popped_flags_word_o(popf));
	// ====================
	// Bus and interrupt tasks
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wbc(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk_i);
			t++;
		end while (ack !== 1'b1 && t < 50);
		chk("ack", 32'h1, 32'(ack));
		rd = dat;
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		wbc(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask
	task automatic step(input logic tr, input logic [3:0] s, input logic take);
		int t;
		t = 0;
		bnd <= 1'b1;
		trap <= tr;
		@(posedge clk_i);
		bnd <= 1'b0;
		trap <= 1'b0;
		@(posedge clk_i);
		chk("push_req", 32'(take), 32'(push_req));
		if (take) begin
			while (vv !== 1'b1 && t < 50) begin
				@(posedge clk_i);
				t++;
			end
			chk("vector", tr ? 16'hfffc : 16'hfffa - {11'h0, s, 1'b0}, 32'(va));
			bnd <= 1'b1;
			@(posedge clk_i);
			bnd <= 1'b0;
			pc <= 14'h1 << s;
			pf <= pf & ~(14'h1 << s);
			rfs <= 1'b1;
			@(posedge clk_i);
			chk("preempt", 32'h0, 32'(push_req));
			pc <= 14'h0;
			rfs <= 1'b0;
			do @(posedge clk_i); while (pop_req !== 1'b0 && t++ < 50);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ====================
	// Tests
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rdc("sens", `CIC_SENS_OFS, 32'h0);
		rdc("flags", `CIC_FLAGS_OFS, 32'h08);
		rdc("pen", `CIC_PEN_OFS, 32'h0);
		rdc("unmapped", 8'h1c, 32'h0);
		wbc(1'b1, `CIC_PEN_OFS, 32'h3fff);
		pf <= 14'h20;
		step(1'b0, 4'd5, 1'b0);
		wbc(1'b1, `CIC_FLAGS_OFS, 32'h0);
		step(1'b0, 4'd5, 1'b1);
		for (int s = 0; s < 13; s++) begin
			if (s < 1 || s > 4) begin
				dly <= 2'(s);
				pf <= 14'h1 << s;
				@(posedge clk_i);
				step(1'b0, 4'(s), 1'b1);
			end
		end
		pf <= 14'h0a00;
		@(posedge clk_i);
		step(1'b0, 4'd9, 1'b1);
		step(1'b0, 4'd11, 1'b1);
		wbc(1'b1, `CIC_PEN_OFS, 32'h3f7f);
		pf <= 14'h80;
		step(1'b0, 4'd7, 1'b0);
		pf <= 14'h0;
		pc <= 14'h80;
		@(posedge clk_i);
		pc <= 14'h0;
		wbc(1'b1, `CIC_PEN_OFS, 32'h3fff);
		step(1'b0, 4'd7, 1'b0);
		wbc(1'b1, `CIC_FLAGS_OFS, 32'h08);
		step(1'b1, 4'd13, 1'b1);
		wbc(1'b1, `CIC_SENS_OFS, 32'h55);
		rdc("sens", `CIC_SENS_OFS, 32'h0);
		for (int c = 0; c < 4; c++) begin
			wbc(1'b1, `CIC_FLAGS_OFS, 32'h08);
			wbc(1'b1, `CIC_SENS_OFS, 32'(c));
			rdc("sens", `CIC_SENS_OFS, 32'(c));
			wbc(1'b1, `CIC_FLAGS_OFS, 32'h0);
			pa <= 8'hfe;
			@(posedge clk_i);
			step(1'b0, 4'd1, c != 1);
			if (c == 0) step(1'b0, 4'd1, 1'b1);
			pa <= 8'hff;
			@(posedge clk_i);
			step(1'b0, 4'd1, c[0]);
		end
		// Line 0 moved to the second pin of port A: only that pin may trigger it
		wbc(1'b1, `CIC_PINSEL_OFS, 32'h0d);
		for (int i = 0; i < 4; i++) begin
			pa <= i[0] ? 8'hff : i < 2 ? 8'hfd : 8'hfe;
			@(posedge clk_i);
			step(1'b0, 4'd1, i < 2);
		end
		// Halt, active halt and wait in pairs: a source outside the wake set first (no request for wait), then one in the wake set
		for (int i = 0; i < 6; i++) begin
			if (i == 4) begin
				pf <= 14'h0;
				pc <= 14'h3fff;
				@(posedge clk_i);
				pc <= 14'h0;
			end
			if (!i[0]) wbc(1'b1, `CIC_POWER_OFS, i == 0 ? 32'h2 : i == 2 ? 32'h3 : 32'h1);
			h = 1'b0;
			pf <= wk_pf[i];
			repeat (6) begin
				@(posedge clk_i);
				h = h | (wake === 1'b1);
			end
			chk("wake", 32'(i[0]), 32'(h));
		end
		// Reset in mid-run brings the mask, vector and pin choice back
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("vector", 32'hfffe, 32'(va));
		rdc("flags", `CIC_FLAGS_OFS, 32'h08);
		rdc("pinsel", `CIC_PINSEL_OFS, 32'h0c);
		end_sim();
	end
	initial begin
		#100000;
		fail_count++;
		end_sim();
	end
endmodule
